/* File: common/fbmc_if.sv */
// internal link from the timebase and debouncer to the controller core
`timescale 1ns/1ps
interface fbmc_if;
    logic qtick;
    logic pressed;
    modport tbase(output qtick);
    modport deb(output pressed);
    modport core(input qtick, input pressed);
endinterface

/* File: common/fbmc_pkg.sv */
// constants, types and helpers of the front button mode controller
// Notes on behaviour
// R1: a brief button press advances the display mode by one
// R2: in mode A the mode indicator LED stays dark
// R3: in mode D the mode indicator LED flashes yellow/orange
// R4: in mode B the mode indicator LED is steady green
// R5: no press for over a minute returns to mode A
// R6: twelve second hold in mode A loads factory defaults
// R7: release before twelve seconds in mode A cancels the factory reset
// R8: five second hold in mode A or D captures the fault mask
// R9: long press in A, B or D flashes the LED after three seconds
// R10: release before five seconds keeps the old fault mask
// R11: port and power state differing from the mask raises a fault
// R12: five second hold in mode B toggles the ring manager role
// R13: enabling the role with media redundancy off also enables redundancy (by button only; a CTRL write can set the role alone)
// R14: disabling the role by button leaves media redundancy on
// R15: presses from A select B, C, D: off, green, orange, flashing
// R16: a press past the brief limit does not advance; D wraps to A
// R17: the button is synchronised and debounced before timing
package fbmc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int QTR_PER_S = 4;
    localparam int QTR_CYCLES = CLK_HZ / QTR_PER_S;
    localparam int DEB_MS = 10;
    localparam int DEB_CYCLES = CLK_HZ / 1000 * DEB_MS;
    localparam int BRIEF_S = 1;
    localparam int WARN_S = 3;
    localparam int MASK_S = 5;
    localparam int RESET_S = 12;
    localparam int IDLE_S = 60;
    localparam int NPORT = 24;
    localparam int NPWR = 2;
    localparam int NIRQ = 5;

    function automatic logic [7:0] sec_to_q(input int s);
        return 8'(s * QTR_PER_S);
    endfunction

    localparam logic [7:0] BRIEF_Q = sec_to_q(BRIEF_S);
    localparam logic [7:0] WARN_Q = sec_to_q(WARN_S);
    localparam logic [7:0] MASK_Q = sec_to_q(MASK_S);
    localparam logic [7:0] RESET_Q = sec_to_q(RESET_S);
    localparam logic [7:0] IDLE_Q = sec_to_q(IDLE_S);
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_ST = 8'h08;
    localparam logic [7:0] REG_IRQ_MK = 8'h0C;
    localparam logic [7:0] REG_FM_PORT = 8'h10;
    localparam logic [7:0] REG_FM_PWR = 8'h14;

    // field positions
    localparam int CTRL_ROLE = 0;
    localparam int CTRL_MRED = 1;
    localparam int STAT_MODE = 0;
    localparam int STAT_FAULT = 2;
    localparam int STAT_PRESS = 3;
    localparam int IRQ_MODE = 0;
    localparam int IRQ_MASK = 1;
    localparam int IRQ_ROLE = 2;
    localparam int IRQ_FRST = 3;
    localparam int IRQ_FAULT = 4;

    typedef enum logic [1:0] {
        MODE_A = 2'b00,
        MODE_B = 2'b01,
        MODE_C = 2'b10,
        MODE_D = 2'b11
    } fbmc_mode_t;

    typedef enum logic [1:0] {
        PR_IDLE = 2'b00,
        PR_HELD = 2'b01,
        PR_DONE = 2'b10
    } fbmc_press_t;
endpackage

/* File: src/fbmc_debounce.sv */
// button synchroniser and debouncer
`timescale 1ns/1ps
module fbmc_debounce import fbmc_pkg::*; #(
    parameter int DEB_CYC = DEB_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // button pin, low while pressed
    input wire logic btn_n_in,
    // clean level out
    fbmc_if.deb db
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [19:0] cnt;
        logic level;
    } fbmc_db_t;

    fbmc_db_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = ~btn_n_in;
        next_st.s2 = st.s1; // R17
        if (st.s2 == st.level) begin
            next_st.cnt = '0;
        end else if (st.cnt == 20'(DEB_CYC - 1)) begin
            next_st.cnt = '0;
            next_st.level = st.s2; // R17
        end else begin
            next_st.cnt = st.cnt + 20'h00001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign db.pressed = st.level;
endmodule

/* File: src/fbmc_timebase.sv */
// quarter second enable pulse divider
`timescale 1ns/1ps
module fbmc_timebase import fbmc_pkg::*; #(
    parameter int QTR_CYC = QTR_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // enable out
    fbmc_if.tbase tb
);
    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } fbmc_tb_t;

    fbmc_tb_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 24'(QTR_CYC - 1)) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tb.qtick = st.tick;
endmodule

/* File: src/fbmc_top.sv */
// front button mode controller with apb registers
`timescale 1ns/1ps
module fbmc_top import fbmc_pkg::*; #(
    parameter int QTR_CYC = QTR_CYCLES,
    parameter int DEB_CYC = DEB_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // button pin
    input wire logic btn_n_in,
    // present port and supply state
    input wire logic [NPORT-1:0] port_up_in,
    input wire logic [NPWR-1:0] pwr_ok_in,
    // mode indicator led
    output logic led_green_out,
    output logic led_orange_out,
    // configuration and status
    output logic factory_reset_out,
    output logic ring_manager_role_out,
    output logic media_red_out,
    output logic fault_out,
    output logic irq_out
);
    typedef struct packed {
        fbmc_mode_t mode;
        fbmc_press_t pst;
        logic [7:0] hold;
        logic [7:0] idle;
        logic pressed_d;
        logic blink;
        logic role;
        logic mred;
        logic [NPORT-1:0] fm_port;
        logic [NPWR-1:0] fm_pwr;
        logic fault;
        logic [NIRQ-1:0] irq_st;
        logic [NIRQ-1:0] irq_mk;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic led_g;
        logic led_o;
        logic frst;
        logic irq;
    } fbmc_state_t;

    fbmc_state_t st, next_st;
    fbmc_if link();

    logic rel;
    logic press;
    logic warn;
    logic fault_now;
    logic apb_acc;
    logic apb_wr;
    logic [NIRQ-1:0] ev;
    logic [7:0] next_hold;
    logic [31:0] rd;
    logic rd_ok;

    fbmc_timebase #(
        .QTR_CYC(QTR_CYC)
    ) u_tb (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .tb(link.tbase)
    );

    fbmc_debounce #(
        .DEB_CYC(DEB_CYC)
    ) u_db (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .btn_n_in(btn_n_in),
        .db(link.deb)
    );

    function automatic fbmc_mode_t next_mode(input fbmc_mode_t m);
        unique case (m)
            MODE_A: return MODE_B;
            MODE_B: return MODE_C;
            MODE_C: return MODE_D;
            MODE_D: return MODE_A;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        ev = '0;
        next_st.pressed_d = link.pressed;
        press = link.pressed && !st.pressed_d;
        rel = !link.pressed && st.pressed_d;
        next_hold = st.hold;
        next_st.frst = 1'b0;

        // flash phase, 2 Hz
        if (link.qtick) begin
            next_st.blink = ~st.blink;
        end

        // press timing
        unique case (st.pst)
            PR_IDLE: begin
                if (press) begin
                    next_st.pst = PR_HELD;
                    next_st.hold = '0;
                end
            end
            PR_HELD: begin
                if (rel) begin
                    next_st.pst = PR_IDLE;
                    if (st.hold < BRIEF_Q) begin
                        next_st.mode = next_mode(st.mode); // R1 R16
                        ev[IRQ_MODE] = 1'b1;
                    end
                    // early release leaves mask, role and config alone
                end else if (link.qtick) begin
                    if (st.hold != CNT_MAX) begin
                        next_hold = st.hold + 8'h01;
                    end
                    next_st.hold = next_hold;
                    unique case (st.mode)
                        MODE_A: begin
                            if (next_hold == MASK_Q) begin
                                next_st.fm_port = port_up_in; // R8 R10
                                next_st.fm_pwr = pwr_ok_in; // R8
                                ev[IRQ_MASK] = 1'b1;
                            end
                            if (next_hold == RESET_Q) begin
                                next_st.frst = 1'b1; // R6 R7
                                next_st.role = 1'b0;
                                next_st.mred = 1'b0;
                                next_st.irq_mk = '0;
                                next_st.pst = PR_DONE;
                                ev[IRQ_FRST] = 1'b1;
                            end
                        end
                        MODE_D: begin
                            if (next_hold == MASK_Q) begin
                                next_st.fm_port = port_up_in; // R8 R10
                                next_st.fm_pwr = pwr_ok_in; // R8
                                next_st.pst = PR_DONE;
                                ev[IRQ_MASK] = 1'b1;
                            end
                        end
                        MODE_B: begin
                            if (next_hold == MASK_Q) begin
                                next_st.role = ~st.role; // R12
                                if (!st.role && !st.mred) begin
                                    next_st.mred = 1'b1; // R13
                                end
                                // role off keeps mred as is R14
                                next_st.pst = PR_DONE;
                                ev[IRQ_ROLE] = 1'b1;
                            end
                        end
                        MODE_C: begin
                            next_st.hold = next_hold;
                        end
                    endcase
                end
            end
            PR_DONE: begin
                if (rel) begin
                    next_st.pst = PR_IDLE;
                end
            end
            default: begin
                next_st.pst = PR_IDLE;
            end
        endcase

        // idle timeout back to mode A
        if (link.pressed) begin
            next_st.idle = '0;
        end else if (link.qtick && st.idle != CNT_MAX) begin
            next_st.idle = st.idle + 8'h01;
        end
        if (!link.pressed && st.idle > IDLE_Q && st.mode != MODE_A) begin
            next_st.mode = MODE_A; // R5
            ev[IRQ_MODE] = 1'b1;
        end

        // warning flash during a long press
        warn = st.pst == PR_HELD && st.hold >= WARN_Q
            && st.mode != MODE_C; // R9

        // indicator led
        next_st.led_g = 1'b0;
        next_st.led_o = 1'b0;
        if (warn) begin
            if (st.mode == MODE_B) begin
                next_st.led_g = st.blink; // R9
            end else begin
                next_st.led_o = st.blink; // R9
            end
        end else begin
            unique case (st.mode)
                MODE_A: begin
                    next_st.led_g = 1'b0; // R2 R15
                end
                MODE_B: begin
                    next_st.led_g = 1'b1; // R4 R15
                end
                MODE_C: begin
                    next_st.led_o = 1'b1; // R15
                end
                MODE_D: begin
                    next_st.led_o = st.blink; // R3 R15
                end
            endcase
        end

        // fault compare
        fault_now = (port_up_in != st.fm_port)
            || (pwr_ok_in != st.fm_pwr); // R11
        next_st.fault = fault_now;
        if (fault_now && !st.fault) begin
            ev[IRQ_FAULT] = 1'b1;
        end

        // apb: one wait state, write lands with pready high
        apb_acc = psel_in && penable_in && !st.pready;
        apb_wr = psel_in && penable_in && st.pready && pwrite_in;
        rd = '0;
        rd_ok = 1'b1;
        unique case (paddr_in)
            REG_CTRL: begin
                rd[CTRL_ROLE] = st.role;
                rd[CTRL_MRED] = st.mred;
            end
            REG_STATUS: begin
                rd[STAT_MODE +: 2] = st.mode;
                rd[STAT_FAULT] = st.fault;
                rd[STAT_PRESS] = link.pressed;
            end
            REG_IRQ_ST: begin
                rd[NIRQ-1:0] = st.irq_st;
            end
            REG_IRQ_MK: begin
                rd[NIRQ-1:0] = st.irq_mk;
            end
            REG_FM_PORT: begin
                rd[NPORT-1:0] = st.fm_port;
            end
            REG_FM_PWR: begin
                rd[NPWR-1:0] = st.fm_pwr;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
        next_st.pready = apb_acc;
        if (apb_acc) begin
            next_st.prdata = pwrite_in ? 32'h00000000 : rd;
            next_st.pslverr = !rd_ok;
        end else begin
            next_st.pslverr = 1'b0;
        end
        if (apb_wr && rd_ok) begin
            unique case (paddr_in)
                REG_CTRL: begin
                    // button action in the same cycle takes priority
                    if (!ev[IRQ_ROLE] && !ev[IRQ_FRST]) begin
                        next_st.role = pwdata_in[CTRL_ROLE];
                        next_st.mred = pwdata_in[CTRL_MRED];
                    end
                end
                REG_IRQ_ST: begin
                    next_st.irq_st = st.irq_st & ~pwdata_in[NIRQ-1:0];
                end
                REG_IRQ_MK: begin
                    if (!ev[IRQ_FRST]) begin
                        next_st.irq_mk = pwdata_in[NIRQ-1:0];
                    end
                end
                default: begin
                    next_st.irq_st = next_st.irq_st;
                end
            endcase
        end

        // sticky events, set wins over clear
        next_st.irq_st = next_st.irq_st | ev;
        next_st.irq = |(next_st.irq_st & next_st.irq_mk);
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign led_green_out = st.led_g;
    assign led_orange_out = st.led_o;
    assign factory_reset_out = st.frst;
    assign ring_manager_role_out = st.role;
    assign media_red_out = st.mred;
    assign fault_out = st.fault;
    assign irq_out = st.irq;
endmodule

/* File: tb/fbmc_operator.sv */
// operator model pressing the single push button
`timescale 1ns/1ps
module fbmc_operator (
    // clock
    input wire logic clk_in,
    // button pin, pulled up when released
    output logic btn_n_out
);
    initial btn_n_out = 1'b1;
    // keeps the button down without a break for the whole hold
    task automatic hold(input int cyc);
        @(posedge clk_in);
        btn_n_out <= 1'b0;
        repeat (cyc) @(posedge clk_in);
        btn_n_out <= 1'b1;
        repeat (24) @(posedge clk_in);
    endtask
endmodule

/* File: tb/fbmc_top_chk.sv */
// port assertions of the front button mode controller
`timescale 1ns/1ps
module fbmc_top_chk import fbmc_pkg::*; #(
    parameter int QTR_CYC = QTR_CYCLES,
    parameter int DEB_CYC = DEB_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // button and state inputs
    input wire logic btn_n_in,
    input wire logic [NPORT-1:0] port_up_in,
    input wire logic [NPWR-1:0] pwr_ok_in,
    // outputs
    input wire logic led_green_out,
    input wire logic led_orange_out,
    input wire logic factory_reset_out,
    input wire logic ring_manager_role_out,
    input wire logic media_red_out,
    input wire logic fault_out,
    input wire logic irq_out
);
    localparam int RST_CYC = (RESET_S * QTR_PER_S - 1) * QTR_CYC;
    localparam int MSK_CYC = (MASK_S * QTR_PER_S - 1) * QTR_CYC;
    int hold_cnt;
    int rel_cnt;
    logic wr_done;
    assign wr_done = psel_in && penable_in && pwrite_in && pready_out;
    // raw hold length, kept through the debounce lag after release
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            hold_cnt <= 0;
            rel_cnt <= 0;
        end else begin
            rel_cnt <= btn_n_in ? rel_cnt + 1 : 0;
            if (!btn_n_in)
                hold_cnt <= hold_cnt + 1;
            else if (rel_cnt > DEB_CYC + 2)
                hold_cnt <= 0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence
    a_ready_wait: assert property (s_access |=> s_answer)
        else $error("ready not one pulse after access");
    a_err_decode: assert property (pready_out |-> pslverr_out ==
        (paddr_in > REG_FM_PWR || paddr_in[1:0] != 2'h0))
        else $error("error flag does not match address");
    a_wr_rdata: assert property (pready_out && pwrite_in |->
        prdata_out == 32'h0) else $error("read data on write");
    a_frst_hold: assert property (factory_reset_out |-> hold_cnt >= RST_CYC)
        else $error("factory reset without full hold");
    a_frst_pulse: assert property (factory_reset_out |=> !factory_reset_out)
        else $error("factory reset longer than one cycle");
    a_role_hold: assert property ($changed(ring_manager_role_out) &&
        !$past(wr_done) |-> hold_cnt >= MSK_CYC)
        else $error("role changed without full hold");
    a_role_mred: assert property ($rose(ring_manager_role_out) &&
        !$past(wr_done) |-> media_red_out)
        else $error("role on without media redundancy");
    a_mred_keep: assert property ($fell(media_red_out) |->
        factory_reset_out || $past(factory_reset_out) || $past(wr_done))
        else $error("media redundancy dropped by button");
endmodule
bind fbmc_top fbmc_top_chk #(.QTR_CYC(QTR_CYC), .DEB_CYC(DEB_CYC)) i_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .btn_n_in(btn_n_in), .port_up_in(port_up_in), .pwr_ok_in(pwr_ok_in),
    .led_green_out(led_green_out), .led_orange_out(led_orange_out),
    .factory_reset_out(factory_reset_out),
    .ring_manager_role_out(ring_manager_role_out),
    .media_red_out(media_red_out), .fault_out(fault_out),
    .irq_out(irq_out));

/* File: tb/front_button_mode_controller_tb.sv */
// self-checking bench of the front button mode controller
`timescale 1ns/1ps
module front_button_mode_controller_tb import fbmc_pkg::*;;
    logic clk_in, rstn_in, psel_in, penable_in, pwrite_in, btn_n_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic pready_out, pslverr_out, led_green_out, led_orange_out;
    logic [NPORT-1:0] port_up_in;
    logic [NPWR-1:0] pwr_ok_in;
    logic factory_reset_out, ring_manager_role_out, media_red_out;
    logic fault_out, irq_out;
    int err_count = 0;
    int n_tests = 0;
    int frst_cnt = 0;
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    fbmc_top #(.QTR_CYC(8), .DEB_CYC(4)) i_fbmc_top (
        .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .btn_n_in(btn_n_in), .port_up_in(port_up_in), .pwr_ok_in(pwr_ok_in),
        .led_green_out(led_green_out), .led_orange_out(led_orange_out),
        .factory_reset_out(factory_reset_out),
        .ring_manager_role_out(ring_manager_role_out),
        .media_red_out(media_red_out), .fault_out(fault_out),
        .irq_out(irq_out));
    fbmc_operator i_fbmc_operator (.clk_in(clk_in), .btn_n_out(btn_n_in));
    always @(posedge clk_in)
        if (factory_reset_out === 1'b1) frst_cnt <= frst_cnt + 1;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 40);
        chk("pready", 32'h1, {31'h0, pready_out});
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] m, x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, x, q & m);
        chk("pslverr", {31'h0, a > REG_FM_PWR || a[1:0] != 2'h0},
            {31'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic led_cnt(input int n, output logic [31:0] g, o, t);
        logic [1:0] p;
        g = 32'h0;
        o = 32'h0;
        t = 32'h0;
        p = {led_green_out, led_orange_out};
        repeat (n) begin
            @(posedge clk_in);
            g += led_green_out;
            o += led_orange_out;
            if ({led_green_out, led_orange_out} !== p) t++;
            p = {led_green_out, led_orange_out};
        end
    endtask
    task automatic led_chk(input fbmc_mode_t md);
        logic [31:0] g, o, t;
        led_cnt(32, g, o, t);
        chk("led_green", (md == MODE_B) ? 32'h20 : 32'h0, g);
        if (md == MODE_D)
            chk("led_flash", 32'h1, {31'h0, t >= 32'h2});
        else
            chk("led_orange", (md == MODE_C) ? 32'h20 : 32'h0, o);
    endtask
    task automatic t_regs;
        wr(REG_STATUS, 32'hF);
        rd("status", REG_STATUS, 32'hF, 32'h0);
        rd("ctrl", REG_CTRL, 32'h3, 32'h0);
        rd("irq_mask", REG_IRQ_MK, 32'h1F, 32'h0);
        rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        rd("unaligned", 8'h83, 32'hFFFFFFFF, 32'h0);
        wr(REG_CTRL, 32'hFFFFFFFE);
        rd("ctrl_wr", REG_CTRL, 32'hFFFFFFFF, 32'h2);
        wr(REG_CTRL, 32'h0);
    endtask
    task automatic t_modes;
        fbmc_mode_t md;
        led_chk(MODE_A);
        i_fbmc_operator.hold(2);
        rd("glitch", REG_STATUS, 32'h3, 32'h0);
        for (int i = 1; i <= 4; i++) begin
            md = fbmc_mode_t'(2'(i));
            i_fbmc_operator.hold(12);
            rd("mode", REG_STATUS, 32'h3, {30'h0, md});
            led_chk(md);
        end
    endtask
    task automatic t_role;
        logic [31:0] g, o, t;
        i_fbmc_operator.hold(12);
        wr(REG_IRQ_MK, 32'h4);
        fork
            i_fbmc_operator.hold(128);
            begin
                repeat (112) @(posedge clk_in);
                led_cnt(18, g, o, t);
            end
        join
        chk("hold_flash", 32'h1, {31'h0, t != 32'h0});
        rd("role_abort", REG_CTRL, 32'h3, 32'h0);
        rd("mode_b", REG_STATUS, 32'h3, 32'h1);
        i_fbmc_operator.hold(192);
        rd("role_on", REG_CTRL, 32'h3, 32'h3);
        chk("role_pin", 32'h1, {31'h0, ring_manager_role_out});
        chk("mred_pin", 32'h1, {31'h0, media_red_out});
        chk("irq_set", 32'h1, {31'h0, irq_out});
        wr(REG_IRQ_ST, 32'h4);
        repeat (3) @(posedge clk_in);
        chk("irq_clr", 32'h0, {31'h0, irq_out});
        i_fbmc_operator.hold(192);
        rd("role_off", REG_CTRL, 32'h3, 32'h2);
        chk("role_off_pin", 32'h0, {31'h0, ring_manager_role_out});
        chk("mred_kept_pin", 32'h1, {31'h0, media_red_out});
        wr(REG_IRQ_MK, 32'h0);
    endtask
    task automatic t_mask;
        i_fbmc_operator.hold(12);
        i_fbmc_operator.hold(192);
        rd("c_long", REG_STATUS, 32'h3, 32'h2);
        i_fbmc_operator.hold(12);
        port_up_in <= 24'hA5A5A5;
        pwr_ok_in <= 2'h1;
        repeat (3) @(posedge clk_in);
        chk("fault_new", 32'h1, {31'h0, fault_out});
        i_fbmc_operator.hold(128);
        rd("mask_kept", REG_FM_PORT, 32'hFFFFFF, 32'h0);
        i_fbmc_operator.hold(192);
        rd("mask_port", REG_FM_PORT, 32'hFFFFFF, 32'hA5A5A5);
        rd("mask_pwr", REG_FM_PWR, 32'h3, 32'h1);
        chk("fault_ok", 32'h0, {31'h0, fault_out});
        port_up_in <= 24'h5A5A5A;
        pwr_ok_in <= 2'h2;
        repeat (3) @(posedge clk_in);
        chk("fault_dev", 32'h1, {31'h0, fault_out});
        port_up_in <= 24'hA5A5A5;
        pwr_ok_in <= 2'h1;
        i_fbmc_operator.hold(12);
        rd("mode_wrap", REG_STATUS, 32'h3, 32'h0);
    endtask
    task automatic t_frst;
        wr(REG_CTRL, 32'h3);
        i_fbmc_operator.hold(300);
        chk("frst_abort", 32'h0, frst_cnt);
        rd("frst_none", REG_CTRL, 32'h3, 32'h3);
        i_fbmc_operator.hold(420);
        chk("frst_once", 32'h1, frst_cnt);
        rd("frst_cfg", REG_CTRL, 32'h3, 32'h0);
        rd("frst_mode", REG_STATUS, 32'h3, 32'h0);
    endtask
    task automatic t_idle;
        i_fbmc_operator.hold(12);
        repeat (1750) @(posedge clk_in);
        rd("idle_kept", REG_STATUS, 32'h3, 32'h1);
        repeat (300) @(posedge clk_in);
        rd("idle_back", REG_STATUS, 32'h3, 32'h0);
    endtask
    initial begin
        rstn_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h0;
        pwdata_in = 32'h0;
        port_up_in = '0;
        pwr_ok_in = '0;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_regs;
        t_modes;
        t_role;
        t_mask;
        t_frst;
        t_idle;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        $display("watchdog expired");
        err_count++;
        give_verdict;
    end
endmodule
